// [design/iao_map.svh]
// Register map, field positions and timing constants of the alarm input/output unit
// Functional notes
// - Both input channels reset to level mode, each with own enable, mode, inversion.
// - Disabled input channel does not evaluate input; its alarm changes only by a counter-mode clear.
// - Level mode, inversion off: alarm set while input high, cleared while low.
// - Level mode, inversion on: alarm set while input low, cleared while high.
// - Inversion defaults off; setting it selects low-active alarm polarity.
// - Counter mode counts input events; alarm raised when count equals threshold.
// - After firing, counting continues but the alarm is not raised again.
// - Threshold spans 0 to 65535; threshold 0 disables the counter alarm.
// - Threshold acts only in counter mode and is ignored in level mode.
// - Input channels are alarm sources; output channels drive external equipment.
// - Output drives on-action level on alarm assert, off-action level on clear.
// - Output starts in configured initial state: last level, high or low.
// - Each output follows the alarm of one selectable input channel.
// - Output action starts after a 0 to 30000 ms delay; 0 means none.
`ifndef IAO_MAP_SVH
`define IAO_MAP_SVH

`define IAO_NCH 2
`define IAO_CNT_W 16
`define IAO_ADDR_W 8

`define IAO_OFF_IN_CTRL 8'h00
`define IAO_OFF_THR0 8'h04
`define IAO_OFF_THR1 8'h08
`define IAO_OFF_CNT0 8'h0c
`define IAO_OFF_CNT1 8'h10
`define IAO_OFF_OUT_CFG0 8'h14
`define IAO_OFF_OUT_CFG1 8'h18
`define IAO_OFF_STATUS 8'h1c
`define IAO_OFF_INT_STAT 8'h20
`define IAO_OFF_INT_MASK 8'h24

`define IAO_IC_STRIDE 4
`define IAO_IC_EN 0
`define IAO_IC_MODE 1
`define IAO_IC_INV 2
`define IAO_IC_CLR 3

`define IAO_OC_EN 0
`define IAO_OC_ON 2:1
`define IAO_OC_OFF 4:3
`define IAO_OC_INIT 6:5
`define IAO_OC_SRC 7
`define IAO_OC_DLY 31:16

`define IAO_ACT_HIGH 2'h0
`define IAO_ACT_LOW 2'h1
`define IAO_ACT_PULSE 2'h2
`define IAO_INIT_LAST 2'h0
`define IAO_INIT_HIGH 2'h1
`define IAO_INIT_LOW 2'h2

`define IAO_ST_ALARM 1:0
`define IAO_ST_PIN 3:2
`define IAO_ST_OUT 5:4
`define IAO_ST_FIRED 7:6
`define IAO_INT_W 4

`define IAO_MS_NS 1000000
`define IAO_CLK_NS 8
`define IAO_DLY_MAX_MS 16'd30000
`define IAO_PULSE_MS 16'd10

`endif

// [design/iao_pkg.sv]
// Types shared by the alarm input/output unit
package iao_pkg;
  `include "iao_map.svh"

  typedef struct packed {
    logic en;
    logic cnt_mode;
    logic inv;
  } iao_in_cfg_s;

  typedef struct packed {
    logic [15:0] delay;
    logic src;
    logic [1:0] init;
    logic [1:0] off_act;
    logic [1:0] on_act;
    logic en;
  } iao_out_cfg_s;

  typedef enum logic [1:0] {
    IAO_OUT_IDLE,
    IAO_OUT_WAIT,
    IAO_OUT_PULSE
  } iao_out_st_e;
endpackage

// [design/iao_alarm_io.sv]
// Two-channel alarm input unit with alarm-driven outputs and APB registers
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "iao_map.svh"
module iao_alarm_io
#(
  parameter int CYC_PER_MS = `IAO_MS_NS / `IAO_CLK_NS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`IAO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field pins
  input wire logic [`IAO_NCH-1:0] alarm_input_channel,
  input wire logic [`IAO_NCH-1:0] out_last_level,
  output logic [`IAO_NCH-1:0] out_level,
  // Interrupt
  output logic irq
);
  import iao_pkg::*;

  localparam int MSW = $clog2(CYC_PER_MS + 1);
  localparam int CW = `IAO_CNT_W;

  logic [`IAO_NCH-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt, prev_r, prev_nxt;
  logic [`IAO_NCH-1:0] alarm_r, alarm_nxt, fired_r, fired_nxt, adj_w, clr_w;
  logic [CW-1:0] cnt_r [`IAO_NCH];
  logic [CW-1:0] cnt_nxt [`IAO_NCH];
  logic [CW-1:0] thr_r [`IAO_NCH];
  logic [CW-1:0] thr_nxt [`IAO_NCH];
  iao_in_cfg_s in_cfg_r [`IAO_NCH];
  iao_in_cfg_s in_cfg_nxt [`IAO_NCH];
  iao_out_cfg_s out_cfg_r [`IAO_NCH];
  iao_out_cfg_s out_cfg_nxt [`IAO_NCH];
  iao_out_st_e out_st_r [`IAO_NCH];
  iao_out_st_e out_st_nxt [`IAO_NCH];
  logic [15:0] dly_r [`IAO_NCH];
  logic [15:0] dly_nxt [`IAO_NCH];
  logic [`IAO_NCH-1:0] out_lvl_r, out_lvl_nxt, init_done_r, init_done_nxt;
  logic [`IAO_NCH-1:0] pend_on_r, pend_on_nxt, src_prev_r, src_prev_nxt;
  logic [MSW-1:0] ms_cnt_r, ms_cnt_nxt;
  logic ms_tick;
  logic [`IAO_INT_W-1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt, rdata;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, hit;
  logic acc, wr, rd;

  function automatic logic [15:0] clamp_dly(input logic [15:0] d);
    clamp_dly = (d > `IAO_DLY_MAX_MS) ? `IAO_DLY_MAX_MS : d;
  endfunction

  // APB handshake: one wait state, then pready with registered data
  assign acc = psel && penable;
  assign wr = acc && pready_r && pwrite;
  assign rd = acc && pready_r && !pwrite;

  // Read decode
  always_comb
  begin
    rdata = 32'h0;
    hit = 1'b1;
    if (paddr == `IAO_OFF_IN_CTRL)
    begin
      for (int i = 0; i < `IAO_NCH; i++)
      begin
        rdata[i*`IAO_IC_STRIDE+`IAO_IC_EN] = in_cfg_r[i].en;
        rdata[i*`IAO_IC_STRIDE+`IAO_IC_MODE] = in_cfg_r[i].cnt_mode;
        rdata[i*`IAO_IC_STRIDE+`IAO_IC_INV] = in_cfg_r[i].inv;
      end
    end
    else if (paddr == `IAO_OFF_THR0)
      rdata[CW-1:0] = thr_r[0];
    else if (paddr == `IAO_OFF_THR1)
      rdata[CW-1:0] = thr_r[1];
    else if (paddr == `IAO_OFF_CNT0)
      rdata[CW-1:0] = cnt_r[0];
    else if (paddr == `IAO_OFF_CNT1)
      rdata[CW-1:0] = cnt_r[1];
    else if (paddr == `IAO_OFF_OUT_CFG0 || paddr == `IAO_OFF_OUT_CFG1)
    begin
      rdata[`IAO_OC_EN] = out_cfg_r[paddr[3]].en;
      rdata[`IAO_OC_ON] = out_cfg_r[paddr[3]].on_act;
      rdata[`IAO_OC_OFF] = out_cfg_r[paddr[3]].off_act;
      rdata[`IAO_OC_INIT] = out_cfg_r[paddr[3]].init;
      rdata[`IAO_OC_SRC] = out_cfg_r[paddr[3]].src;
      rdata[`IAO_OC_DLY] = out_cfg_r[paddr[3]].delay;
    end
    else if (paddr == `IAO_OFF_STATUS)
    begin
      rdata[`IAO_ST_ALARM] = alarm_r;
      rdata[`IAO_ST_PIN] = sync2_r;
      rdata[`IAO_ST_OUT] = out_lvl_r;
      rdata[`IAO_ST_FIRED] = fired_r;
    end
    else if (paddr == `IAO_OFF_INT_STAT)
      rdata[`IAO_INT_W-1:0] = int_stat_r;
    else if (paddr == `IAO_OFF_INT_MASK)
      rdata[`IAO_INT_W-1:0] = int_mask_r;
    else
      hit = 1'b0;
  end

  // Bus answer and register writes
  always_comb
  begin
    pready_nxt = acc && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (acc && !pready_r)
    begin
      prdata_nxt = rdata;
      pslverr_nxt = !hit;
    end
    int_mask_nxt = int_mask_r;
    clr_w = '0;
    for (int i = 0; i < `IAO_NCH; i++)
    begin
      in_cfg_nxt[i] = in_cfg_r[i];
      thr_nxt[i] = thr_r[i];
      out_cfg_nxt[i] = out_cfg_r[i];
    end
    if (wr)
    begin
      if (paddr == `IAO_OFF_IN_CTRL)
      begin
        for (int i = 0; i < `IAO_NCH; i++)
        begin
          in_cfg_nxt[i].en = pwdata[i*`IAO_IC_STRIDE+`IAO_IC_EN];
          in_cfg_nxt[i].cnt_mode = pwdata[i*`IAO_IC_STRIDE+`IAO_IC_MODE];
          in_cfg_nxt[i].inv = pwdata[i*`IAO_IC_STRIDE+`IAO_IC_INV];
          clr_w[i] = pwdata[i*`IAO_IC_STRIDE+`IAO_IC_CLR];
        end
      end
      else if (paddr == `IAO_OFF_THR0)
        thr_nxt[0] = pwdata[CW-1:0];
      else if (paddr == `IAO_OFF_THR1)
        thr_nxt[1] = pwdata[CW-1:0];
      else if (paddr == `IAO_OFF_OUT_CFG0 || paddr == `IAO_OFF_OUT_CFG1)
      begin
        out_cfg_nxt[paddr[3]].en = pwdata[`IAO_OC_EN];
        out_cfg_nxt[paddr[3]].on_act = pwdata[`IAO_OC_ON];
        out_cfg_nxt[paddr[3]].off_act = pwdata[`IAO_OC_OFF];
        out_cfg_nxt[paddr[3]].init = pwdata[`IAO_OC_INIT];
        out_cfg_nxt[paddr[3]].src = pwdata[`IAO_OC_SRC];
        out_cfg_nxt[paddr[3]].delay = clamp_dly(pwdata[`IAO_OC_DLY]);
      end
      else if (paddr == `IAO_OFF_INT_MASK)
        int_mask_nxt = pwdata[`IAO_INT_W-1:0];
    end
  end

  // Input channels: synchronise, polarity, level and counter alarms
  always_comb
  begin
    sync1_nxt = alarm_input_channel;
    sync2_nxt = sync1_r;
    for (int i = 0; i < `IAO_NCH; i++)
    begin
      adj_w[i] = sync2_r[i] ^ in_cfg_r[i].inv;
      prev_nxt[i] = adj_w[i];
      alarm_nxt[i] = alarm_r[i];
      fired_nxt[i] = fired_r[i];
      cnt_nxt[i] = cnt_r[i];
      if (clr_w[i])
      begin
        cnt_nxt[i] = '0;
        fired_nxt[i] = 1'b0;
        if (in_cfg_r[i].cnt_mode)
          alarm_nxt[i] = 1'b0;
      end
      else if (in_cfg_r[i].en)
      begin
        if (!in_cfg_r[i].cnt_mode)
          alarm_nxt[i] = adj_w[i];
        else if (adj_w[i] && !prev_r[i])
        begin
          if (cnt_r[i] != '1)
            cnt_nxt[i] = CW'(cnt_r[i] + 1'b1);
          if (thr_r[i] != '0 && !fired_r[i] && CW'(cnt_r[i] + 1'b1) == thr_r[i])
          begin
            alarm_nxt[i] = 1'b1;
            fired_nxt[i] = 1'b1;
          end
        end
      end
    end
  end

  // Millisecond time base
  always_comb
  begin
    ms_tick = (ms_cnt_r == MSW'(CYC_PER_MS - 1));
    ms_cnt_nxt = ms_tick ? '0 : MSW'(ms_cnt_r + 1'b1);
  end

  // Output channels
  always_comb
  begin
    logic a;
    logic [1:0] act;
    a = 1'b0;
    act = `IAO_ACT_LOW;
    for (int i = 0; i < `IAO_NCH; i++)
    begin
      out_st_nxt[i] = out_st_r[i];
      dly_nxt[i] = dly_r[i];
      out_lvl_nxt[i] = out_lvl_r[i];
      init_done_nxt[i] = init_done_r[i];
      pend_on_nxt[i] = pend_on_r[i];
      a = alarm_r[out_cfg_r[i].src];
      act = pend_on_r[i] ? out_cfg_r[i].on_act : out_cfg_r[i].off_act;
      src_prev_nxt[i] = a;
      if (!out_cfg_r[i].en)
      begin
        out_st_nxt[i] = IAO_OUT_IDLE;
        src_prev_nxt[i] = 1'b0;
      end
      else if (!init_done_r[i])
      begin
        init_done_nxt[i] = 1'b1;
        src_prev_nxt[i] = 1'b0;
        if (out_cfg_r[i].init == `IAO_INIT_LAST)
          out_lvl_nxt[i] = out_last_level[i];
        else
          out_lvl_nxt[i] = (out_cfg_r[i].init == `IAO_INIT_HIGH);
      end
      else if (a != src_prev_r[i])
      begin
        pend_on_nxt[i] = a;
        dly_nxt[i] = out_cfg_r[i].delay;
        out_st_nxt[i] = IAO_OUT_WAIT;
      end
      else
      begin
        case (out_st_r[i])
          IAO_OUT_WAIT:
          begin
            if (dly_r[i] == '0)
            begin
              out_st_nxt[i] = IAO_OUT_IDLE;
              out_lvl_nxt[i] = (act != `IAO_ACT_LOW);
              if (act == `IAO_ACT_PULSE)
              begin
                dly_nxt[i] = `IAO_PULSE_MS;
                out_st_nxt[i] = IAO_OUT_PULSE;
              end
            end
            else if (ms_tick)
              dly_nxt[i] = dly_r[i] - 1'b1;
          end
          IAO_OUT_PULSE:
          begin
            if (dly_r[i] == '0)
            begin
              out_lvl_nxt[i] = 1'b0;
              out_st_nxt[i] = IAO_OUT_IDLE;
            end
            else if (ms_tick)
              dly_nxt[i] = dly_r[i] - 1'b1;
          end
          default:
            out_st_nxt[i] = IAO_OUT_IDLE;
        endcase
      end
    end
  end

  // Interrupt status: raise events low, clear events high; set beats read-clear
  always_comb
  begin
    int_stat_nxt = int_stat_r;
    // Clear only what the read reported; later events survive
    if (rd && paddr == `IAO_OFF_INT_STAT)
      int_stat_nxt = int_stat_r & ~prdata_r[`IAO_INT_W-1:0];
    int_stat_nxt = int_stat_nxt | {alarm_r & ~alarm_nxt, alarm_nxt & ~alarm_r};
    irq_nxt = |(int_stat_nxt & int_mask_nxt);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      alarm_r <= '0;
      fired_r <= '0;
      out_lvl_r <= '0;
      init_done_r <= '0;
      pend_on_r <= '0;
      src_prev_r <= '0;
      ms_cnt_r <= '0;
      int_stat_r <= '0;
      int_mask_r <= '0;
      irq_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      for (int i = 0; i < `IAO_NCH; i++)
      begin
        in_cfg_r[i] <= '0;
        thr_r[i] <= '0;
        cnt_r[i] <= '0;
        out_cfg_r[i] <= '{delay: 16'h0, src: 1'b0, init: `IAO_INIT_LOW,
                          off_act: `IAO_ACT_LOW, on_act: `IAO_ACT_HIGH, en: 1'b0};
        out_st_r[i] <= IAO_OUT_IDLE;
        dly_r[i] <= '0;
      end
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      alarm_r <= alarm_nxt;
      fired_r <= fired_nxt;
      out_lvl_r <= out_lvl_nxt;
      init_done_r <= init_done_nxt;
      pend_on_r <= pend_on_nxt;
      src_prev_r <= src_prev_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      in_cfg_r <= in_cfg_nxt;
      thr_r <= thr_nxt;
      cnt_r <= cnt_nxt;
      out_cfg_r <= out_cfg_nxt;
      out_st_r <= out_st_nxt;
      dly_r <= dly_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign out_level = out_lvl_r;
  assign irq = irq_r;

  // Level and output checks on channel 0, counter checks on channel 1
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_act_due;
    out_st_r[0] == IAO_OUT_WAIT && dly_r[0] == '0 && out_cfg_r[0].en && init_done_r[0]
      && alarm_r[out_cfg_r[0].src] == src_prev_r[0];
  endsequence

  a_disabled_hold: assert property (!in_cfg_r[0].en && !clr_w[0] |=> $stable(alarm_r[0]))
    else $error("disabled channel changed its alarm");
  a_level_high: assert property (in_cfg_r[0].en && !in_cfg_r[0].cnt_mode && !in_cfg_r[0].inv
    && !clr_w[0] |=> alarm_r[0] == $past(sync2_r[0]))
    else $error("level alarm does not follow high input");
  a_level_low: assert property (in_cfg_r[0].en && !in_cfg_r[0].cnt_mode && in_cfg_r[0].inv
    && !clr_w[0] |=> alarm_r[0] == !$past(sync2_r[0]))
    else $error("inverted level alarm does not follow low input");
  a_count_fire: assert property (in_cfg_r[1].en && in_cfg_r[1].cnt_mode && !clr_w[1]
    && adj_w[1] && !prev_r[1] && !fired_r[1] && thr_r[1] != '0
    && CW'(cnt_r[1] + 1'b1) == thr_r[1] |=> alarm_r[1] && fired_r[1])
    else $error("counter alarm missed threshold");
  a_no_refire: assert property (in_cfg_r[1].cnt_mode && fired_r[1] && !clr_w[1]
    |=> !$rose(alarm_r[1]))
    else $error("counter alarm raised twice");
  a_zero_thr: assert property (in_cfg_r[1].cnt_mode && thr_r[1] == '0 && !alarm_r[1]
    |=> !alarm_r[1])
    else $error("zero threshold raised alarm");
  a_count_edge: assert property (in_cfg_r[1].en && in_cfg_r[1].cnt_mode && !clr_w[1]
    && adj_w[1] && !prev_r[1] && cnt_r[1] != '1 |=> cnt_r[1] == CW'($past(cnt_r[1]) + 1'b1))
    else $error("event not counted");
  a_clear_rearm: assert property (clr_w[1] |=> cnt_r[1] == '0 && !fired_r[1])
    else $error("clear did not reset counter");
  a_on_action: assert property (s_act_due ##0 pend_on_r[0]
    && out_cfg_r[0].on_act == `IAO_ACT_HIGH |=> out_level[0] ##1 1'b1)
    else $error("on action did not drive high");
  a_delay_start: assert property (out_cfg_r[0].en && init_done_r[0]
    && alarm_r[out_cfg_r[0].src] != src_prev_r[0]
    |=> out_st_r[0] == IAO_OUT_WAIT && dly_r[0] == $past(out_cfg_r[0].delay))
    else $error("delay not loaded on alarm change");
endmodule // iao_alarm_io

// [testbench/iao_field_model.sv]
// Field contacts and switches wired to the alarm inputs
`timescale 1ns/1ps
`include "iao_map.svh"
module iao_field_model
(
  // Clock
  input wire logic sys_clk,
  // Contacts and remembered output levels
  output logic [`IAO_NCH-1:0] alarm_input_channel,
  output logic [`IAO_NCH-1:0] out_last_level
);
  initial
  begin
    alarm_input_channel = '0;
    out_last_level = '0;
  end

  // Contact moves right after an edge, then stays for hold cycles
  task drive(input int ch, input logic v, input int hold);
    alarm_input_channel[ch] <= v;
    repeat (hold) @(posedge sys_clk);
  endtask

  // One closing and opening of a contact, wide enough for the synchroniser
  task pulse(input int ch);
    drive(ch, 1'b1, 3);
    drive(ch, 1'b0, 3);
  endtask

  task set_last(input logic [`IAO_NCH-1:0] v);
    out_last_level <= v;
    @(posedge sys_clk);
  endtask
endmodule // iao_field_model

// [testbench/testbench.sv]
// Self-checking bench for the alarm input/output unit
`timescale 1ns/1ps
`include "iao_map.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`IAO_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`IAO_NCH-1:0] alarm_input_channel;
  logic [`IAO_NCH-1:0] out_last_level;
  logic [`IAO_NCH-1:0] out_level;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] d;
  logic e;

  always #(`IAO_CLK_NS / 2) sys_clk = ~sys_clk;

  // Short millisecond so delays stay a few cycles
  iao_alarm_io #(.CYC_PER_MS(4)) iao_alarm_io_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_input_channel(alarm_input_channel),
    .out_last_level(out_last_level), .out_level(out_level), .irq(irq));

  iao_field_model iao_field_model_i (
    .sys_clk(sys_clk), .alarm_input_channel(alarm_input_channel),
    .out_last_level(out_last_level));

  task complete_run;
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; entered right after a rising edge, idle edge at the end
  task apb(input logic wr, input logic [`IAO_ADDR_W-1:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task rchk(input string nm, input logic [`IAO_ADDR_W-1:0] a, input logic [31:0] m,
            input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, d & m, x);
  endtask

  task t_reset;
    rchk("in_ctrl", `IAO_OFF_IN_CTRL, 32'hffffffff, 32'h0);
    rchk("thr0", `IAO_OFF_THR0, 32'hffffffff, 32'h0);
    rchk("out_cfg0", `IAO_OFF_OUT_CFG0, 32'hffffffff, 32'h48);
    rchk("int_mask", `IAO_OFF_INT_MASK, 32'hffffffff, 32'h0);
    chk("out_level", 32'(out_level), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, 8'h30, 32'h1234);
    chk("wr unmapped err", 32'(e), 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk("rd unmapped err", 32'(e), 32'h1);
    chk("rd unmapped data", d, 32'h0);
    apb(1'b1, `IAO_OFF_CNT0, 32'h5);
    rchk("cnt0 ro", `IAO_OFF_CNT0, 32'hffff, 32'h0);
  endtask

  task t_level;
    iao_field_model_i.drive(0, 1'b1, 6);
    rchk("alarm disabled", `IAO_OFF_STATUS, 32'h3, 32'h0);
    apb(1'b1, `IAO_OFF_THR0, 32'h1);
    apb(1'b1, `IAO_OFF_IN_CTRL, 32'h1);
    rchk("alarm high", `IAO_OFF_STATUS, 32'h3, 32'h1);
    iao_field_model_i.drive(1, 1'b1, 6);
    rchk("ch1 disabled", `IAO_OFF_STATUS, 32'h3, 32'h1);
    iao_field_model_i.drive(0, 1'b0, 6);
    rchk("alarm low", `IAO_OFF_STATUS, 32'h3, 32'h0);
    apb(1'b1, `IAO_OFF_IN_CTRL, 32'h5);
    rchk("inv low", `IAO_OFF_STATUS, 32'h3, 32'h1);
    iao_field_model_i.drive(0, 1'b1, 6);
    rchk("inv high", `IAO_OFF_STATUS, 32'h3, 32'h0);
    iao_field_model_i.drive(1, 1'b0, 6);
    iao_field_model_i.drive(0, 1'b0, 6);
  endtask

  task t_counter;
    apb(1'b1, `IAO_OFF_IN_CTRL, 32'h31);
    apb(1'b1, `IAO_OFF_THR1, 32'h3);
    apb(1'b0, `IAO_OFF_INT_STAT, 32'h0);
    repeat (2) iao_field_model_i.pulse(1);
    rchk("cnt1 two", `IAO_OFF_CNT1, 32'hffff, 32'h2);
    rchk("below thr", `IAO_OFF_STATUS, 32'h2, 32'h0);
    iao_field_model_i.pulse(1);
    rchk("at thr", `IAO_OFF_STATUS, 32'h82, 32'h82);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, `IAO_OFF_INT_MASK, 32'h2);
    chk("irq unmasked", 32'(irq), 32'h1);
    rchk("int raised", `IAO_OFF_INT_STAT, 32'h2, 32'h2);
    chk("irq after read", 32'(irq), 32'h0);
    iao_field_model_i.pulse(1);
    rchk("cnt1 past thr", `IAO_OFF_CNT1, 32'hffff, 32'h4);
    rchk("no second", `IAO_OFF_INT_STAT, 32'h2, 32'h0);
    rchk("alarm kept", `IAO_OFF_STATUS, 32'h2, 32'h2);
    apb(1'b1, `IAO_OFF_IN_CTRL, 32'hb1);
    rchk("cnt1 cleared", `IAO_OFF_CNT1, 32'hffff, 32'h0);
    rchk("rearmed", `IAO_OFF_STATUS, 32'h2, 32'h0);
    apb(1'b1, `IAO_OFF_THR1, 32'h0);
    repeat (2) iao_field_model_i.pulse(1);
    rchk("thr zero cnt", `IAO_OFF_CNT1, 32'hffff, 32'h2);
    rchk("thr zero", `IAO_OFF_STATUS, 32'h2, 32'h0);
    apb(1'b1, `IAO_OFF_THR1, 32'hffff);
    rchk("thr max", `IAO_OFF_THR1, 32'hffff, 32'hffff);
    apb(1'b1, `IAO_OFF_INT_MASK, 32'h0);
  endtask

  task t_output;
    int n;
    apb(1'b1, `IAO_OFF_IN_CTRL, 32'h11);
    apb(1'b1, `IAO_OFF_OUT_CFG0, 32'h23);
    @(posedge sys_clk);
    chk("init high", 32'(out_level), 32'h1);
    iao_field_model_i.set_last(2'b10);
    apb(1'b1, `IAO_OFF_OUT_CFG1, 32'h00030089);
    @(posedge sys_clk);
    chk("init last", 32'(out_level), 32'h3);
    iao_field_model_i.drive(0, 1'b1, 8);
    chk("on action", 32'(out_level), 32'h2);
    iao_field_model_i.drive(0, 1'b0, 8);
    chk("off action", 32'(out_level), 32'h3);
    iao_field_model_i.drive(1, 1'b1, 30);
    chk("on high", 32'(out_level), 32'h3);
    iao_field_model_i.drive(1, 1'b0, 0);
    n = 0;
    while (out_level[1] !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("delay span", 32'(n >= 11 && n <= 20), 32'h1);
    chk("off low", 32'(out_level), 32'h1);
    // Channel 0: on action high, off action a 10 ms pulse
    apb(1'b1, `IAO_OFF_OUT_CFG0, 32'h31);
    iao_field_model_i.drive(0, 1'b1, 8);
    iao_field_model_i.drive(0, 1'b0, 8);
    chk("pulse high", 32'(out_level[0]), 32'h1);
    repeat (48) @(posedge sys_clk);
    chk("pulse end", 32'(out_level[0]), 32'h0);
    iao_field_model_i.drive(0, 1'b1, 8);
    chk("on again", 32'(out_level[0]), 32'h1);
  endtask

  initial
  begin
    sys_rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_level;
    t_counter;
    t_output;
    complete_run;
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #(`IAO_CLK_NS * 40000);
    num_errors++;
    complete_run;
  end
endmodule // testbench
